/* mac_interrupt_enable_status.sv */
// interrupt enable and latched interrupt status for the mac queue manager
`timescale 1ns/1ps
//
// Contract
// - enable bit 15 gates link change onto the interrupt pin
// - enable bit 14 gates transmit done onto the interrupt pin
// - enable bit 13 gates receive done onto the interrupt pin
// - enable bit 12 gates transmit underrun onto the interrupt pin
// - enable bit 11 gates receive overrun onto the interrupt pin
// - enable bit 10 gates early receive onto the interrupt pin
// - enable bit 9 gates transmit process stopped onto the interrupt pin
// - enable bit 8 gates receive process stopped onto the interrupt pin
// - enable bit 7 gates receive error frame onto the interrupt pin
// - interrupt pin asserts when any status bit and its enable are set
// - reading status returns latched bits and never clears them
// - status bits set on edges, cleared only by writing one
// - status bit 15 sets on any link state change
// - status bit 14 sets when transmit queue sent a frame
// - status bit 13 sets when receive queue holds a complete frame
// - status bit 12 sets on transmit underrun
// - status bit 11 sets on receive overrun
// - status bit 10 sets on early receive
// - status bit 9 sets on transmit stop, resets to one
// - status bit 8 sets on receive stop, resets to one
// - status bit 7 sets on receive error frame
module mac_interrupt_enable_status
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire mac_irq_pkg::reg_req_t i_req,
    input wire mac_irq_pkg::irq_sources_t i_src,
    output logic [mac_irq_pkg::DATA_W-1:0] o_rdata,
    output logic o_irq
);
    import mac_irq_pkg::*;

    // ==========================================================
    // decode
    logic hit_enable;
    logic hit_status;
    assign hit_enable = (i_req.addr == OFS_INTERRUPT_ENABLE);
    assign hit_status = (i_req.addr == OFS_INTERRUPT_STATUS);

    // ==========================================================
    // edge detection of the sources
    irq_sources_t src_prev_r;
    logic link_seen_r;
    logic [DATA_W-1:0] set_vec;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            src_prev_r <= '0;
            link_seen_r <= 1'b0;
        end
        else
        begin
            src_prev_r <= i_src;
            link_seen_r <= 1'b1;
        end
    end

    // link state is a level; the first cycle after reset only learns it,
    // so an already-up link does not fake a change
    always_comb
    begin
        set_vec = '0;
        set_vec[BIT_LINK_CHANGE] = link_seen_r &
            (i_src.link_up ^ src_prev_r.link_up);
        set_vec[BIT_TX_DONE] =
            i_src.tx_done & ~src_prev_r.tx_done;
        set_vec[BIT_RX_DONE] =
            i_src.rx_done & ~src_prev_r.rx_done;
        set_vec[BIT_TX_UNDERRUN] =
            i_src.tx_underrun & ~src_prev_r.tx_underrun;
        set_vec[BIT_RX_OVERRUN] =
            i_src.rx_overrun & ~src_prev_r.rx_overrun;
        set_vec[BIT_EARLY_RX] =
            i_src.early_rx & ~src_prev_r.early_rx;
        set_vec[BIT_TX_STOPPED] =
            i_src.tx_stopped & ~src_prev_r.tx_stopped;
        set_vec[BIT_RX_STOPPED] =
            i_src.rx_stopped & ~src_prev_r.rx_stopped;
        set_vec[BIT_RX_ERROR_FRAME] =
            i_src.rx_error_frame & ~src_prev_r.rx_error_frame;
    end

    // ==========================================================
    // enable register
    logic [DATA_W-1:0] enable_r;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            enable_r <= ENABLE_RESET;
        else if (i_req.wr && hit_enable)
            enable_r <= i_req.wdata & IMPL_MASK;
    end

    // ==========================================================
    // status register, write one to clear
    logic [DATA_W-1:0] clear_vec;
    logic link_change_flag;
    logic tx_done_flag;
    logic rx_done_flag;
    logic tx_underrun_flag;
    logic rx_overrun_flag;
    logic early_rx_flag;
    logic tx_stopped_flag;
    logic rx_stopped_flag;
    logic rx_error_frame_flag;
    logic [DATA_W-1:0] status_word;

    // only implemented bits can be cleared; reserved bits have no flop
    always_comb
    begin
        clear_vec = '0;
        if (i_req.wr && hit_status)
            clear_vec = i_req.wdata & IMPL_MASK;
    end

    // ==========================================================
    // one flag per source; a set in the same cycle as its clear wins,
    // so no event is lost
    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_LINK_CHANGE])
    )
    i_link_change
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_LINK_CHANGE]),
        .i_clear(clear_vec[BIT_LINK_CHANGE]),
        .o_flag(link_change_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_TX_DONE])
    )
    i_tx_done
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_TX_DONE]),
        .i_clear(clear_vec[BIT_TX_DONE]),
        .o_flag(tx_done_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_RX_DONE])
    )
    i_rx_done
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_RX_DONE]),
        .i_clear(clear_vec[BIT_RX_DONE]),
        .o_flag(rx_done_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_TX_UNDERRUN])
    )
    i_tx_underrun
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_TX_UNDERRUN]),
        .i_clear(clear_vec[BIT_TX_UNDERRUN]),
        .o_flag(tx_underrun_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_RX_OVERRUN])
    )
    i_rx_overrun
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_RX_OVERRUN]),
        .i_clear(clear_vec[BIT_RX_OVERRUN]),
        .o_flag(rx_overrun_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_EARLY_RX])
    )
    i_early_rx
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_EARLY_RX]),
        .i_clear(clear_vec[BIT_EARLY_RX]),
        .o_flag(early_rx_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_TX_STOPPED])
    )
    i_tx_stopped
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_TX_STOPPED]),
        .i_clear(clear_vec[BIT_TX_STOPPED]),
        .o_flag(tx_stopped_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_RX_STOPPED])
    )
    i_rx_stopped
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_RX_STOPPED]),
        .i_clear(clear_vec[BIT_RX_STOPPED]),
        .o_flag(rx_stopped_flag)
    );

    status_flag
    #(
        .RESET_VAL(STATUS_RESET[BIT_RX_ERROR_FRAME])
    )
    i_rx_error_frame
    (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(set_vec[BIT_RX_ERROR_FRAME]),
        .i_clear(clear_vec[BIT_RX_ERROR_FRAME]),
        .o_flag(rx_error_frame_flag)
    );

    // ==========================================================
    // status word as software reads it, reserved bits read as zero
    always_comb
    begin
        status_word = '0;
        status_word[BIT_LINK_CHANGE] = link_change_flag;
        status_word[BIT_TX_DONE] = tx_done_flag;
        status_word[BIT_RX_DONE] = rx_done_flag;
        status_word[BIT_TX_UNDERRUN] = tx_underrun_flag;
        status_word[BIT_RX_OVERRUN] = rx_overrun_flag;
        status_word[BIT_EARLY_RX] = early_rx_flag;
        status_word[BIT_TX_STOPPED] = tx_stopped_flag;
        status_word[BIT_RX_STOPPED] = rx_stopped_flag;
        status_word[BIT_RX_ERROR_FRAME] = rx_error_frame_flag;
    end

    // ==========================================================
    // read port, data in the cycle after the strobe only
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_rdata <= RDATA_RESET;
        else if (i_req.rd)
        begin
            case (1'b1)
                hit_enable: o_rdata <= enable_r;
                hit_status: o_rdata <= status_word;
                default: o_rdata <= RDATA_RESET;
            endcase
        end
        else
            o_rdata <= RDATA_RESET;
    end

    // ==========================================================
    // per source gating onto the pin
    logic [DATA_W-1:0] pending;

    always_comb
    begin
        pending = '0;
        pending[BIT_LINK_CHANGE] =
            link_change_flag & enable_r[BIT_LINK_CHANGE];
        pending[BIT_TX_DONE] =
            tx_done_flag & enable_r[BIT_TX_DONE];
        pending[BIT_RX_DONE] =
            rx_done_flag & enable_r[BIT_RX_DONE];
        pending[BIT_TX_UNDERRUN] =
            tx_underrun_flag & enable_r[BIT_TX_UNDERRUN];
        pending[BIT_RX_OVERRUN] =
            rx_overrun_flag & enable_r[BIT_RX_OVERRUN];
        pending[BIT_EARLY_RX] =
            early_rx_flag & enable_r[BIT_EARLY_RX];
        pending[BIT_TX_STOPPED] =
            tx_stopped_flag & enable_r[BIT_TX_STOPPED];
        pending[BIT_RX_STOPPED] =
            rx_stopped_flag & enable_r[BIT_RX_STOPPED];
        pending[BIT_RX_ERROR_FRAME] =
            rx_error_frame_flag & enable_r[BIT_RX_ERROR_FRAME];
    end

    // ==========================================================
    // interrupt pin, registered so it never glitches toward the host
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_irq <= 1'b0;
        else
            o_irq <= |pending;
    end

endmodule : mac_interrupt_enable_status

// ==========================================================
// one latched event flag, write one to clear
module status_flag
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_set,
    input wire logic i_clear,
    output logic o_flag
);

    logic flag_nxt;

    // set is applied last so an event in the clearing cycle is kept
    always_comb
    begin
        flag_nxt = o_flag;
        if (i_clear)
            flag_nxt = 1'b0;
        if (i_set)
            flag_nxt = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_flag <= RESET_VAL;
        else
            o_flag <= flag_nxt;
    end

endmodule : status_flag

/* mac_irq_pkg.sv */
// constants and carrier types for the mac interrupt enable and status block
package mac_irq_pkg;

    // ==========================================================
    // register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_STATUS = 8'h02;

    // ==========================================================
    // bit positions, shared by enable and status
    localparam int BIT_LINK_CHANGE = 15;
    localparam int BIT_TX_DONE = 14;
    localparam int BIT_RX_DONE = 13;
    localparam int BIT_TX_UNDERRUN = 12;
    localparam int BIT_RX_OVERRUN = 11;
    localparam int BIT_EARLY_RX = 10;
    localparam int BIT_TX_STOPPED = 9;
    localparam int BIT_RX_STOPPED = 8;
    localparam int BIT_RX_ERROR_FRAME = 7;

    // bits 15..7 implemented, 6..0 reserved and read as zero
    localparam logic [DATA_W-1:0] IMPL_MASK = 16'hFF80;

    // ==========================================================
    // values after reset
    localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0300;
    localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

    // ==========================================================
    // event sources, one bit per status flag, in status-bit order
    typedef struct packed {
        logic link_up;
        logic tx_done;
        logic rx_done;
        logic tx_underrun;
        logic rx_overrun;
        logic early_rx;
        logic tx_stopped;
        logic rx_stopped;
        logic rx_error_frame;
    } irq_sources_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : mac_irq_pkg

/* host_model.sv */
// host side of the register port
`timescale 1ns/1ps
module host_model
(
    input wire logic i_clk,
    input wire logic [mac_irq_pkg::DATA_W-1:0] i_rdata,
    output mac_irq_pkg::reg_req_t o_req
);
    import mac_irq_pkg::*;
    initial o_req = '0;
    // ========
    // bus cycle
    // entered just after a rising edge; back to back calls leave no gap
    task automatic xfer(input logic [7:0] a, input logic [15:0] d,
        input logic w, output logic [15:0] q);
        o_req <= '{a, d, w, !w};
        @(posedge i_clk) o_req <= '0;
        #1 q = i_rdata;
    endtask : xfer
endmodule : host_model

/* mac_irq_chk.sv */
// port assertions for the interrupt block
`timescale 1ns/1ps
module mac_irq_chk
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire mac_irq_pkg::reg_req_t i_req,
    input wire mac_irq_pkg::irq_sources_t i_src,
    input wire logic [mac_irq_pkg::DATA_W-1:0] o_rdata,
    input wire logic o_irq
);
    import mac_irq_pkg::*;
    wire [8:0] s = i_src;
    // ========
    // checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence rd_st;
        i_req.rd && i_req.addr == 8'h02;
    endsequence
    sequence wr_at(a, d);
        i_req.wr && i_req.addr == a && i_req.wdata == d;
    endsequence
    a_rdata_idle: assert property (!i_req.rd |=> o_rdata == 16'h0000)
        else $error("stray read data");
    a_rsvd_zero: assert property (i_req.rd |=> o_rdata[6:0] == 7'h00)
        else $error("reserved bits set");
    a_read_keeps: assert property (
        rd_st ##0 !$changed(i_src) ##1 rd_st |=> $stable(o_rdata))
        else $error("read changed status");
    for (genvar i = 0; i < 8; i++)
    begin : g_flag
        a_flag_sets: assert property (
            $rose(s[i]) ##1 rd_st |=> o_rdata[7+i])
            else $error("flag not set");
    end
    a_link_flag: assert property ($changed(s[8]) ##1 rd_st |=> o_rdata[15])
        else $error("link flag not set");
    a_w1c_clear: assert property (
        wr_at(8'h02, 16'hFFFF) ##0 !$changed(i_src) ##1 rd_st
        |=> o_rdata == 16'h0000)
        else $error("status not cleared");
    a_irq_match: assert property (
        wr_at(8'h00, 16'hFFFF) ##1 rd_st |=> o_irq == (o_rdata != 16'h0000))
        else $error("irq differs from status");
    a_irq_drop: assert property (wr_at(8'h00, 16'h0000) |=> ##1 !o_irq)
        else $error("irq stuck");
endmodule : mac_irq_chk
bind mac_interrupt_enable_status mac_irq_chk i_chk (.i_clk(i_clk),
    .i_reset(i_reset), .i_req(i_req), .i_src(i_src), .o_rdata(o_rdata),
    .o_irq(o_irq));

/* tb.sv */
// self-checking bench for the interrupt enable and status block
`timescale 1ns/1ps
module tb;
    import mac_irq_pkg::*;
    typedef struct {logic [8:0] s; logic [15:0] en, st; logic irq;} row_t;
    row_t rows[18];
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    reg_req_t req;
    irq_sources_t src = '0;
    logic [15:0] rdata, q;
    logic irq;
    int err_total = 0;
    int comparisons = 0;
    initial forever #2.5 i_clk = ~i_clk;
    mac_interrupt_enable_status i_dut (.i_clk(i_clk), .i_reset(i_reset),
        .i_req(req), .i_src(src), .o_rdata(rdata), .o_irq(irq));
    host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input string n, input logic [7:0] a, input logic [15:0] e);
        i_host.xfer(a, 16'h0000, 1'b0, q);
        chk(n, e, q);
    endtask : rd
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    // ========
    // rows, then reset and awkward cases
    initial
    begin
        // upper rows disable only their own source, so irq must stay low
        for (int k = 0; k < 18; k++)
        begin
            rows[k].s = 9'h001 << (k % 9);
            rows[k].st = 16'h0080 << (k % 9);
            rows[k].en = (k < 9) ? rows[k].st : 16'hFF80 ^ rows[k].st;
            rows[k].irq = k < 9;
        end
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        i_host.xfer(8'h02, 16'hFFFF, 1'b1, q);
        foreach (rows[k])
        begin
            i_host.xfer(8'h00, rows[k].en, 1'b1, q);
            @(posedge i_clk) src <= irq_sources_t'(src ^ rows[k].s);
            @(posedge i_clk) src <= irq_sources_t'(src ^ rows[k].s);
            rd("status", 8'h02, rows[k].st);
            @(posedge i_clk) #1;
            chk("irq", {15'h0, rows[k].irq}, {15'h0, irq});
            i_host.xfer(8'h02, rows[k].st, 1'b1, q);
            @(posedge i_clk) #1;
            chk("irq low", 16'h0000, {15'h0, irq});
            $display("row %0d done", k);
        end
        @(posedge i_clk) i_reset <= 1'b1;
        @(posedge i_clk) i_reset <= 1'b0;
        rd("enable", 8'h00, 16'h0000);
        i_host.xfer(8'h00, 16'hFFFF, 1'b1, q);
        rd("status", 8'h02, 16'h0300);
        rd("reread", 8'h02, 16'h0300);
        i_host.xfer(8'h02, 16'h0000, 1'b1, q);
        rd("enable", 8'h00, 16'hFF80);
        chk("irq", 16'h0001, {15'h0, irq});
        i_host.xfer(8'h00, 16'h0000, 1'b1, q);
        rd("unmapped", 8'h04, 16'h0000);
        i_host.xfer(8'h02, 16'hFFFF, 1'b1, q);
        rd("cleared", 8'h02, 16'h0000);
        $display("register tests done");
        conclude();
    end
    initial
    begin
        #20us;
        err_total++;
        conclude();
    end
endmodule : tb
